// ---- dv/port_status_reset_rate_limit_tb_top.sv ----
`timescale 1ns/1ps
module port_status_reset_rate_limit_tb_top;
    import switch_regs_pkg::*;
    localparam int WIN = 10000;
    localparam int TICKS = WIN / TICK_CYCLES;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, far_end_fault = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] polarity_reversed = 2'h0, crossover_algo_select;
    logic [2:0] tx_flow_active = 3'h0, rx_flow_active = 3'h0, speed_100 = 3'h0;
    logic [2:0] full_duplex = 3'h0;
    logic       soft_reset, pcs_reset, limit_speed_100 = 1'b1, soft_m = 1'b0;
    logic [6:0] ingress_rate_code = 7'h00, egress_rate_code = 7'h00;
    logic       ingress_valid = 1'b0, egress_valid = 1'b0, ingress_ready, egress_ready;
    logic       xo [3] = '{1'b1, 1'b1, 1'b1};
    logic [7:0] port_addr [3] = '{ADDR_P1_STATUS_B, ADDR_P2_STATUS_B, ADDR_P3_STATUS_B};
    logic [31:0] seed = 32'h3B82;
    int         errors = 0;
    int         n_compared = 0;
    logic [7:0] exp_q [$];

    port_status_reset_rate_limit port_status_reset_rate_limit_inst (
        .clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .polarity_reversed, .tx_flow_active, .rx_flow_active, .speed_100, .full_duplex,
        .far_end_fault, .crossover_algo_select, .soft_reset, .pcs_reset, .limit_speed_100,
        .ingress_rate_code, .egress_rate_code, .ingress_valid, .ingress_ready,
        .egress_valid, .egress_ready);

    // The clock toggles every half period of 2 ns.
    always #2 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected status byte from the modelled select bits and the live inputs.
    function automatic logic [7:0] status_exp(input int p);
        return {xo[p], 1'b0, (p < 2) ? polarity_reversed[p] : 1'b0, tx_flow_active[p],
                rx_flow_active[p], speed_100[p], full_duplex[p], (p == 0) && far_end_fault};
    endfunction

    // Modelled rate in kbps; zero means the code imposes no limit.
    function automatic int kbps(input logic spd, input logic [6:0] c);
        if (c >= CODE_SUB_FIRST && c <= CODE_SUB_LAST)
            return (int'(c) - 16'h64) * KBPS_SUB_STEP;
        if (c != 7'h00 && c <= (spd ? CODE_MAX_100 : CODE_MAX_10))
            return int'(c) * KBPS_PER_MBPS;
        return 0;
    endfunction

    task automatic report_and_stop;
        $display("Comparisons: %0d, mismatches: %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    // A read strobe is answered by a one-cycle valid pulse on the next cycle.
    task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(negedge clock);
        reg_addr = addr;
        reg_rd = 1'b1;
        exp_q.push_back(exp);
        @(negedge clock);
        reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01, "read valid");
        check(reg_rdata, exp_q.pop_front(), what);
        @(negedge clock);
        check({7'h00, reg_rvalid}, 8'h00, "read valid width");
    endtask

    // Writes the select bit with the reserved bit left at zero and all status bits set.
    task automatic write_xover(input int p, input logic v);
        write_reg(port_addr[p], {v, 1'b0, 6'h3F});
        if (!soft_m)
            xo[p] = v;
        @(negedge clock);
        check({6'h00, crossover_algo_select}, {6'h00, xo[1], xo[0]}, "select outputs");
        read_reg(port_addr[p], status_exp(p), "select readback");
    endtask

    task automatic check_range(input int got, input int kb, input string what);
        int lo;
        int hi;
        lo = (kb == 0) ? WIN - 3 : kb * (TICKS - 1) / BYTE_COST_MB - 1;
        hi = (kb == 0) ? WIN : kb * (TICKS + 1) / BYTE_COST_MB + 1;
        n_compared++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("ERROR at %0t: %s passed %0d bytes, expected %0d..%0d", $time, what,
                     got, lo, hi);
        end
    endtask

    // Clears credit with a software reset, then offers bytes on both paths for a window.
    task automatic measure(input logic spd, input logic [6:0] icode, input logic [6:0] ecode);
        int ni;
        int ne;
        ni = 0;
        ne = 0;
        limit_speed_100 = spd;
        ingress_rate_code = icode;
        egress_rate_code = ecode;
        write_reg(ADDR_RESET_CTRL, 8'h10);
        write_reg(ADDR_RESET_CTRL, 8'h00);
        xo = '{1'b1, 1'b1, 1'b1};
        ingress_valid = 1'b1;
        egress_valid = 1'b1;
        repeat (WIN)
        begin
            @(negedge clock);
            ni += (ingress_ready === 1'b1);
            ne += (egress_ready === 1'b1);
        end
        ingress_valid = 1'b0;
        egress_valid = 1'b0;
        check_range(ni, kbps(spd, icode), "ingress");
        check_range(ne, kbps(spd, ecode), "egress");
    endtask

    // Main sequence: reset, registers, then the rate limiters.
    initial
    begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        for (int p = 0; p < 3; p++)
            read_reg(port_addr[p], status_exp(p), "reset status");
        check({6'h00, crossover_algo_select}, 8'h03, "reset selects");
        read_reg(ADDR_RESET_CTRL, RESET_CTRL_RESET, "reset control");
        for (int i = 0; i < 24; i++)
        begin
            @(negedge clock);
            seed = lfsr(seed);
            {polarity_reversed, tx_flow_active, rx_flow_active, speed_100, full_duplex,
             far_end_fault} = seed[14:0];
            read_reg(port_addr[i % 3], status_exp(i % 3), "status");
        end
        write_xover(2, 1'b0);
        write_xover(0, 1'b0);
        write_xover(1, 1'b0);
        read_reg(8'h44, 8'h00, "unmapped read");
        write_reg(ADDR_RESET_CTRL, 8'h01);
        check({6'h00, soft_reset, pcs_reset}, 8'h01, "coding reset only");
        write_reg(ADDR_RESET_CTRL, 8'h11);
        soft_m = 1'b1;
        xo = '{1'b1, 1'b1, 1'b1};
        check({6'h00, soft_reset, pcs_reset}, 8'h03, "both resets");
        write_xover(0, 1'b0);
        read_reg(ADDR_RESET_CTRL, 8'h11, "reset bits held");
        write_reg(ADDR_RESET_CTRL, 8'h00);
        soft_m = 1'b0;
        check({6'h00, soft_reset, pcs_reset}, 8'h00, "resets cleared");
        measure(1'b1, CODE_NONE, CODE_FULL_100);
        measure(1'b1, 7'h05, CODE_MAX_100);
        measure(1'b0, 7'h03, CODE_FULL_10);
        measure(1'b0, CODE_NONE, CODE_MAX_10);
        measure(1'b1, CODE_SUB_LAST, 7'h6A);
        measure(1'b0, CODE_SUB_FIRST, 7'h6F);
        report_and_stop;
    end

    // Watchdog that ends a hung run after a span well beyond the expected length.
    initial
    begin
        #400000;
        errors++;
        report_and_stop;
    end
endmodule

// ---- verilog/port_status_reset_rate_limit.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Status bit 7 selects crossover algorithm, read-write, resets to one.
// - Crossover select only drives the two copper ports; port three bit does nothing.
// - Bit 5 reads copper port receive polarity reversal; zero on port three.
// - Bit 4 reads one while transmit flow control is active.
// - Bit 3 reads one while receive flow control is active.
// - Bit 2 reads one at 100 Mbps, zero at 10 Mbps.
// - Bit 1 reads one at full duplex, zero at half duplex.
// - Bit 0 reads far-end fault, meaningful on port one only.
// - Reset register bit 4 returns all other registers to reset values.
// - Reset register bit 0 resets the PHY coding sublayer.
// - At 100BT codes 1 to 0x63 limit to that many Mbps.
// - At 100BT codes 0 and 0x64 mean no limit.
// - At 10BT codes 1 to 0x09 limit to that many Mbps.
// - At 10BT codes 0 and 0x0A mean no limit.
// - Codes 0x65 to 0x73 give 64 kbps steps up to 960 kbps.
module port_status_reset_rate_limit (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic [1:0] polarity_reversed,
    input  wire logic [2:0] tx_flow_active,
    input  wire logic [2:0] rx_flow_active,
    input  wire logic [2:0] speed_100,
    input  wire logic [2:0] full_duplex,
    input  wire logic       far_end_fault,
    output logic      [1:0] crossover_algo_select,
    output logic            soft_reset,
    output logic            pcs_reset,
    input  wire logic       limit_speed_100,
    input  wire logic [6:0] ingress_rate_code,
    input  wire logic [6:0] egress_rate_code,
    input  wire logic       ingress_valid,
    output logic            ingress_ready,
    input  wire logic       egress_valid,
    output logic            egress_ready
);
    import switch_regs_pkg::*;

    typedef struct packed {
        logic [2:0] xover;
        logic       soft_rst;
        logic       pcs_rst;
        logic [7:0] rdata;
        logic       rvalid;
        logic [7:0] tick_cnt;
        logic       tick;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    rate_if ingress_link ();
    rate_if egress_link ();

    // Builds the secondary status byte of one port from the live status inputs.
    function automatic logic [7:0] status_byte(input int p, input logic xsel);
        logic [7:0] b;
        b = 8'h00;
        b[XOVER_BIT]  = xsel;
        b[RSVD_BIT]   = RSVD_VALUE;
        b[POLRV_BIT]  = (p < 2) ? polarity_reversed[p[0]] : 1'b0;
        b[TXFC_BIT]   = tx_flow_active[p];
        b[RXFC_BIT]   = rx_flow_active[p];
        b[SPEED_BIT]  = speed_100[p];
        b[DUPLEX_BIT] = full_duplex[p];
        b[FEFAULT_BIT] = (p == 0) ? far_end_fault : 1'b0;
        return b;
    endfunction

    // Register reads, writes, software reset and the one-microsecond tick.
    always_comb
    begin
        next_state = state;
        next_state.rvalid = 1'b0;
        next_state.tick = 1'b0;
        if (state.tick_cnt == 8'(TICK_CYCLES - 1))
        begin
            next_state.tick_cnt = 8'h00;
            next_state.tick = 1'b1;
        end
        else
        begin
            next_state.tick_cnt = state.tick_cnt + 8'h01;
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_P1_STATUS_B: next_state.xover[0] = reg_wdata[XOVER_BIT];
                ADDR_P2_STATUS_B: next_state.xover[1] = reg_wdata[XOVER_BIT];
                ADDR_P3_STATUS_B: next_state.xover[2] = reg_wdata[XOVER_BIT];
                ADDR_RESET_CTRL:
                begin
                    next_state.soft_rst = reg_wdata[SOFT_RST_BIT];
                    next_state.pcs_rst  = reg_wdata[PCS_RST_BIT];
                end
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            next_state.rvalid = 1'b1;
            unique case (reg_addr)
                ADDR_P1_STATUS_B: next_state.rdata = status_byte(0, state.xover[0]);
                ADDR_P2_STATUS_B: next_state.rdata = status_byte(1, state.xover[1]);
                ADDR_P3_STATUS_B: next_state.rdata = status_byte(2, state.xover[2]);
                ADDR_RESET_CTRL:
                begin
                    next_state.rdata = RESET_CTRL_RESET;
                    next_state.rdata[SOFT_RST_BIT] = state.soft_rst;
                    next_state.rdata[PCS_RST_BIT]  = state.pcs_rst;
                end
                default: next_state.rdata = 8'h00;
            endcase
        end
        // Held software reset keeps all other registers at their reset values.
        if (state.soft_rst)
            next_state.xover = {3{XOVER_RESET}};
    end

    // State register with synchronous reset.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= '0;
            state.xover <= {3{XOVER_RESET}};
        end
        else
        begin
            state <= next_state;
        end
    end

    // Only the copper ports drive a crossover engine.
    assign crossover_algo_select = state.xover[1:0];
    assign soft_reset = state.soft_rst;
    assign pcs_reset  = state.pcs_rst;
    assign reg_rdata  = state.rdata;
    assign reg_rvalid = state.rvalid;

    // Ingress and egress limiters share the tick and the software reset.
    assign ingress_link.tick   = state.tick;
    assign ingress_link.clear  = state.soft_rst;
    assign ingress_link.is_100 = limit_speed_100;
    assign ingress_link.code   = ingress_rate_code;
    assign ingress_link.valid  = ingress_valid;
    assign ingress_ready       = ingress_link.ready;
    assign egress_link.tick    = state.tick;
    assign egress_link.clear   = state.soft_rst;
    assign egress_link.is_100  = limit_speed_100;
    assign egress_link.code    = egress_rate_code;
    assign egress_link.valid   = egress_valid;
    assign egress_ready        = egress_link.ready;

    rate_limiter ingress_limiter (
        .clock (clock),
        .rst_n (rst_n),
        .lim   (ingress_link.limiter)
    );

    rate_limiter egress_limiter (
        .clock (clock),
        .rst_n (rst_n),
        .lim   (egress_link.limiter)
    );

    // Checks on register behaviour.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_xover_write: assert property (
        reg_wr && reg_addr == ADDR_P1_STATUS_B && !state.soft_rst
        |=> crossover_algo_select[0] == $past(reg_wdata[XOVER_BIT]))
        else $error("Port 1 crossover select did not take the written value.");
    a_port3_inert: assert property (
        reg_wr && reg_addr == ADDR_P3_STATUS_B && !state.soft_rst
        |=> $stable(crossover_algo_select))
        else $error("Port 3 write changed a copper crossover select.");
    a_port3_polarity: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B |=> reg_rvalid && !reg_rdata[POLRV_BIT])
        else $error("Port 3 reported polarity reversal.");
    a_tx_flow_read: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B
        |=> reg_rdata[TXFC_BIT] == $past(tx_flow_active[1]))
        else $error("Port 2 transmit flow flag mismatched.");
    a_rx_flow_read: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[RXFC_BIT] == $past(rx_flow_active[0]))
        else $error("Port 1 receive flow flag mismatched.");
    a_speed_read: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B
        |=> reg_rdata[SPEED_BIT] == $past(speed_100[2]))
        else $error("Port 3 speed flag mismatched.");
    a_duplex_read: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B
        |=> reg_rdata[DUPLEX_BIT] == $past(full_duplex[1]))
        else $error("Port 2 duplex flag mismatched.");
    a_fault_port2: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B |=> !reg_rdata[FEFAULT_BIT])
        else $error("Port 2 reported far-end fault.");
    a_soft_reset_xover: assert property (
        soft_reset ##1 soft_reset |-> crossover_algo_select == 2'h3)
        else $error("Software reset did not restore crossover selects.");
    a_pcs_write: assert property (
        reg_wr && reg_addr == ADDR_RESET_CTRL
        |=> pcs_reset == $past(reg_wdata[PCS_RST_BIT])
            && soft_reset == $past(reg_wdata[SOFT_RST_BIT]))
        else $error("Reset register bits did not take the written value.");
    a_tick_period: assert property (
        state.tick |=> (!state.tick) [*8])
        else $error("Microsecond tick fired too often.");

    // Crossover selects: write, hold, read back and the software reset override.
    a_xover_port2: assert property (
        reg_wr && reg_addr == ADDR_P2_STATUS_B && !state.soft_rst
        |=> crossover_algo_select[1] == $past(reg_wdata[XOVER_BIT]))
        else $error("Port 2 crossover select did not take the written value.");

    a_xover_hold: assert property (
        !(reg_wr && reg_addr == ADDR_P1_STATUS_B) && !soft_reset
        |=> $stable(crossover_algo_select[0]))
        else $error("Port 1 crossover select changed without a write.");

    a_xover_readback: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[XOVER_BIT] == $past(crossover_algo_select[0]))
        else $error("Port 1 crossover select read back wrongly.");

    a_soft_override: assert property (
        soft_reset && reg_wr && reg_addr == ADDR_P1_STATUS_B
        |=> crossover_algo_select[0])
        else $error("Crossover write took effect during software reset.");

    // Status fields of each port against the live inputs at the read edge.
    a_polarity_port1: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[POLRV_BIT] == $past(polarity_reversed[0]))
        else $error("Port 1 polarity flag mismatched.");

    a_polarity_port2: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B
        |=> reg_rdata[POLRV_BIT] == $past(polarity_reversed[1]))
        else $error("Port 2 polarity flag mismatched.");

    a_tx_flow_port1: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[TXFC_BIT] == $past(tx_flow_active[0]))
        else $error("Port 1 transmit flow flag mismatched.");

    a_tx_flow_port3: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B
        |=> reg_rdata[TXFC_BIT] == $past(tx_flow_active[2]))
        else $error("Port 3 transmit flow flag mismatched.");

    a_rx_flow_port2: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B
        |=> reg_rdata[RXFC_BIT] == $past(rx_flow_active[1]))
        else $error("Port 2 receive flow flag mismatched.");

    a_rx_flow_port3: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B
        |=> reg_rdata[RXFC_BIT] == $past(rx_flow_active[2]))
        else $error("Port 3 receive flow flag mismatched.");

    a_speed_port1: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[SPEED_BIT] == $past(speed_100[0]))
        else $error("Port 1 speed flag mismatched.");

    a_speed_port2: assert property (
        reg_rd && reg_addr == ADDR_P2_STATUS_B
        |=> reg_rdata[SPEED_BIT] == $past(speed_100[1]))
        else $error("Port 2 speed flag mismatched.");

    a_duplex_port1: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[DUPLEX_BIT] == $past(full_duplex[0]))
        else $error("Port 1 duplex flag mismatched.");

    a_duplex_port3: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B
        |=> reg_rdata[DUPLEX_BIT] == $past(full_duplex[2]))
        else $error("Port 3 duplex flag mismatched.");

    a_fault_port1: assert property (
        reg_rd && reg_addr == ADDR_P1_STATUS_B
        |=> reg_rdata[FEFAULT_BIT] == $past(far_end_fault))
        else $error("Port 1 far-end fault flag mismatched.");

    a_fault_port3: assert property (
        reg_rd && reg_addr == ADDR_P3_STATUS_B |=> !reg_rdata[FEFAULT_BIT])
        else $error("Port 3 reported far-end fault.");

    a_reserved_zero: assert property (
        reg_rd |=> !reg_rdata[RSVD_BIT])
        else $error("Reserved status bit read as one.");

    // Reset register bits hold until written; the software reset bit clears the limiters while set.
    a_reset_readback: assert property (
        reg_rd && reg_addr == ADDR_RESET_CTRL
        |=> reg_rdata[SOFT_RST_BIT] == $past(soft_reset)
            && reg_rdata[PCS_RST_BIT] == $past(pcs_reset))
        else $error("Reset register read back wrongly.");

    a_reset_hold: assert property (
        !(reg_wr && reg_addr == ADDR_RESET_CTRL)
        |=> $stable(soft_reset) && $stable(pcs_reset))
        else $error("Reset register bits changed without a write.");

    a_limiter_clear: assert property (
        soft_reset |=> !ingress_ready && !egress_ready)
        else $error("Software reset did not close the rate limiters.");

    // Read answer timing and unmapped addresses.
    a_read_answer: assert property (
        reg_rd |=> reg_rvalid)
        else $error("Read strobe was not answered one cycle later.");

    a_no_stray_valid: assert property (
        !reg_rd |=> !reg_rvalid)
        else $error("Read valid rose without a read strobe.");

    a_unmapped_zero: assert property (
        reg_rd && reg_addr != ADDR_P1_STATUS_B && reg_addr != ADDR_P2_STATUS_B
        && reg_addr != ADDR_P3_STATUS_B && reg_addr != ADDR_RESET_CTRL
        |=> reg_rdata == 8'h00)
        else $error("Unmapped address did not read as zero.");

    c_xover_zero: cover property (reg_wr && reg_addr == ADDR_P2_STATUS_B
                                  && !reg_wdata[XOVER_BIT]);
    c_soft_reset: cover property ($rose(soft_reset) ##[1:20] $fell(soft_reset));
    c_status_read: cover property (reg_rd && reg_addr == ADDR_P1_STATUS_B
                                   ##1 reg_rdata[FEFAULT_BIT]);
    c_soft_write: cover property (soft_reset && reg_wr && reg_addr == ADDR_P1_STATUS_B);
endmodule

// ---- verilog/rate_if.sv ----
`timescale 1ns/1ps
interface rate_if;
    logic       tick;
    logic       clear;
    logic       is_100;
    logic [6:0] code;
    logic       valid;
    logic       ready;

    modport ctrl    (output tick, output clear, output is_100, output code,
                     output valid, input ready);
    modport limiter (input tick, input clear, input is_100, input code,
                     input valid, output ready);
endinterface

// ---- verilog/rate_limiter.sv ----
`timescale 1ns/1ps
module rate_limiter #(
    parameter int BUCKET = switch_regs_pkg::BUCKET_MB
) (
    input  wire logic   clock,
    input  wire logic   rst_n,
    rate_if.limiter     lim
);
    import switch_regs_pkg::*;

    typedef struct packed {
        logic [23:0] credit;
        logic        unlim;
        logic        ready;
    } lim_state_t;

    lim_state_t state;
    lim_state_t next_state;

    // Returns the allowed rate in kbps, or zero when the code means no limit.
    function automatic logic [16:0] limit_kbps(input logic [6:0] code,
                                               input logic is_100);
        logic [16:0] r;
        r = 17'h00000;
        if (code >= CODE_SUB_FIRST && code <= CODE_SUB_LAST)
            r = 17'((code - 7'h64) * KBPS_SUB_STEP);
        else if (is_100 && code != CODE_NONE && code <= CODE_MAX_100)
            r = 17'(code * KBPS_PER_MBPS);
        else if (!is_100 && code != CODE_NONE && code <= CODE_MAX_10)
            r = 17'(code * KBPS_PER_MBPS);
        return r;
    endfunction

    assign lim.ready = state.ready;

    // Token bucket: spend a byte's cost per transfer, refill once per microsecond.
    always_comb
    begin
        logic [24:0] sum;
        logic [16:0] kbps;
        sum = 25'h0000000;
        kbps = limit_kbps(lim.code, lim.is_100);
        next_state = state;
        next_state.unlim = (kbps == 17'h00000);
        if (lim.valid && state.ready && state.credit >= 24'(BYTE_COST_MB))
            next_state.credit = state.credit - 24'(BYTE_COST_MB);
        if (lim.tick)
        begin
            sum = {1'b0, next_state.credit} + {8'h00, kbps};
            next_state.credit = (sum > 25'(BUCKET)) ? 24'(BUCKET) : sum[23:0];
        end
        next_state.ready = next_state.unlim
                           || next_state.credit >= 24'(BYTE_COST_MB);
        if (lim.clear)
            next_state = '0;
    end

    // State register with synchronous reset.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_no_limit_open: assert property (state.unlim && !lim.clear |-> state.ready)
        else $error("Unlimited code did not leave the limiter open.");
    a_credit_spend: assert property (
        lim.valid && state.ready && !state.unlim && !lim.tick && !lim.clear
        |=> state.credit == $past(state.credit) - 24'(BYTE_COST_MB))
        else $error("Limited transfer did not spend one byte of credit.");
    c_limited_stall: cover property (lim.valid && !state.ready && !state.unlim);
endmodule

// ---- verilog/switch_regs_pkg.sv ----
package switch_regs_pkg;

    // Register addresses on the management register port.
    localparam logic [7:0] ADDR_P1_STATUS_B = 8'h1F;
    localparam logic [7:0] ADDR_P2_STATUS_B = 8'h2F;
    localparam logic [7:0] ADDR_P3_STATUS_B = 8'h3F;
    localparam logic [7:0] ADDR_RESET_CTRL  = 8'h43;

    // Field positions in the per-port secondary status register.
    localparam int XOVER_BIT   = 7;
    localparam int RSVD_BIT    = 6;
    localparam int POLRV_BIT   = 5;
    localparam int TXFC_BIT    = 4;
    localparam int RXFC_BIT    = 3;
    localparam int SPEED_BIT   = 2;
    localparam int DUPLEX_BIT  = 1;
    localparam int FEFAULT_BIT = 0;

    // Field positions in the global reset register.
    localparam int SOFT_RST_BIT = 4;
    localparam int PCS_RST_BIT  = 0;

    // Reset values.
    localparam logic       XOVER_RESET = 1'b1;
    localparam logic       RSVD_VALUE  = 1'b0;
    localparam logic [7:0] RESET_CTRL_RESET = 8'h00;

    // Rate-limit code points.
    localparam logic [6:0] CODE_NONE      = 7'h00;
    localparam logic [6:0] CODE_MAX_100   = 7'h63;
    localparam logic [6:0] CODE_FULL_100  = 7'h64;
    localparam logic [6:0] CODE_MAX_10    = 7'h09;
    localparam logic [6:0] CODE_FULL_10   = 7'h0A;
    localparam logic [6:0] CODE_SUB_FIRST = 7'h65;
    localparam logic [6:0] CODE_SUB_LAST  = 7'h73;
    localparam int         KBPS_PER_MBPS  = 1000;
    localparam int         KBPS_SUB_STEP  = 64;

    // Credit is kept in millibits; a byte costs eight thousand of them.
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int BYTE_COST_MB  = 8000;
    localparam int BUCKET_MB     = 12144000;

endpackage
